// ==== core/psw_top.sv ====
// Behaviour
// - Software sets a channel's transmit float bit to tristate its line driver.
// - Transmit port A code 1110 is low-active float input, 1000 high-active.
// - Transmit line floats when register bit OR asserted port input is true.
// - Low-active port: float equals register bit OR inverted pin level.
// - Every channel owns its float bit and port, switching works across devices.
// - Receive system float bit holds data, signaling, clock, marker outputs high-Z, no pulls.
// - Receive port configured as float input: effective control is bit XOR pin.
// - Effective receive float 1 tristates all four outputs regardless of slot enable.
// - Effective 0: slot enable 0 never floats; 1 floats data/signaling with pull-up when idle.
// - Shared board signal low: channel 1 active; high: channel 2 active.
// - Line monitor bit puts the equalizer in monitor mode, 20 dB more sensitive.
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module psw_top
    import psw_pkg::*;
#(
    parameter int N_CH = NUM_CH
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [N_CH-1:0] tx_multi_port_a_i,
    input wire logic [N_CH-1:0] rx_multi_port_a_i,
    input wire logic [N_CH-1:0] rx_slot_active_i,
    output logic [N_CH-1:0] tx_line_oe_o,
    output logic [N_CH-1:0] rx_data_oe_o,
    output logic [N_CH-1:0] rx_signaling_oe_o,
    output logic [N_CH-1:0] rx_sys_clock_oe_o,
    output logic [N_CH-1:0] rx_frame_marker_oe_o,
    output logic [N_CH-1:0] rx_pullup_en_o,
    output logic [N_CH-1:0] line_monitor_mode_o,
    output logic [N_CH-1:0] term_resistor_switch_o,
    output logic [N_CH-1:0] analog_switch_o
);

    // Bus decode
    logic req;
    logic wr_stb;
    logic [CH_SEL_W-1:0] adr_ch;
    logic [3:0] adr_reg;
    logic ch_ok;
    logic ack_r;
    logic [DATA_W-1:0] rd_nxt;
    logic [DATA_W-1:0] rd_r;

    // Per-channel register state
    logic [CTRL_W-1:0] ctrl_r [N_CH];
    logic [PCFG_W-1:0] pcfg_r [N_CH];
    logic [EVT_W-1:0] evt_r [N_CH];
    logic [N_CH-1:0] tx_float_prev_r;
    logic [N_CH-1:0] rx_float_prev_r;
    logic [N_CH-1:0] line_mon_r;
    logic [N_CH-1:0] term_sw_r;
    logic [N_CH-1:0] analog_sw_r;

    // Per-channel combinational results
    logic [N_CH-1:0] tx_float;
    logic [N_CH-1:0] rx_float;
    logic [N_CH-1:0] tx_fn_on;
    logic [N_CH-1:0] rx_fn_on;
    logic [N_CH-1:0] rx_data_oe;
    logic [N_CH-1:0] rx_clk_oe;
    logic [N_CH-1:0] rx_pullup;
    logic [STAT_W-1:0] stat [N_CH];

    assign req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr_stb = req & wb_we_i;
    assign adr_ch = wb_adr_i[CH_SEL_LSB +: CH_SEL_W];
    assign adr_reg = wb_adr_i[CH_SEL_LSB-1:0];
    assign ch_ok = (32'(adr_ch) < N_CH);

    // One wait cycle per access; ack drops the cycle after it was given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    assign wb_ack_o = ack_r;

    // Read mux: unmapped channels and offsets read as zero but still ack
    always_comb begin
        rd_nxt = DATA_ZERO;
        if (ch_ok) begin
            case (adr_reg)
                REG_CTRL: begin
                    rd_nxt[CTRL_W-1:0] = ctrl_r[adr_ch[$clog2(N_CH)-1:0]];
                end
                REG_PORTCFG: begin
                    rd_nxt[PCFG_W-1:0] = pcfg_r[adr_ch[$clog2(N_CH)-1:0]];
                end
                REG_STATUS: begin
                    rd_nxt[STAT_W-1:0] = stat[adr_ch[$clog2(N_CH)-1:0]];
                end
                REG_EVENT: begin
                    rd_nxt[EVT_W-1:0] = evt_r[adr_ch[$clog2(N_CH)-1:0]];
                end
                default: begin
                    rd_nxt = DATA_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_r <= DATA_ZERO;
        end else if (req && !wb_we_i) begin
            rd_r <= rd_nxt;
        end
    end

    assign wb_dat_o = rd_r;

    genvar g;
    generate
        for (g = 0; g < N_CH; g++) begin : g_ch
            logic sel_ch;
            logic wr_ctrl;
            logic wr_pcfg;
            logic wr_evt;
            logic [EVT_W-1:0] evt_set;
            logic [EVT_W-1:0] evt_clr;

            psw_chan_if ch_if ();

            assign sel_ch = ch_ok && (32'(adr_ch) == g);
            assign wr_ctrl = wr_stb & sel_ch & (adr_reg == REG_CTRL) & wb_sel_i[0];
            assign wr_pcfg = wr_stb & sel_ch & (adr_reg == REG_PORTCFG) & wb_sel_i[0];
            assign wr_evt = wr_stb & sel_ch & (adr_reg == REG_EVENT) & wb_sel_i[0];

            // Each channel has private bits and a private port
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    ctrl_r[g] <= CTRL_RST;
                end else if (wr_ctrl) begin
                    ctrl_r[g] <= wb_dat_i[CTRL_W-1:0];
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pcfg_r[g] <= PCFG_RST;
                end else if (wr_pcfg) begin
                    pcfg_r[g] <= wb_dat_i[PCFG_W-1:0];
                end
            end

            assign ch_if.tx_line_float_bit = ctrl_r[g][CTRL_TX_FLOAT];
            assign ch_if.tx_port_a_function = pcfg_r[g][PCFG_TX_LSB +: FN_W];
            assign ch_if.tx_multi_port_a = tx_multi_port_a_i[g];
            assign ch_if.rx_sys_float_bit = ctrl_r[g][CTRL_RX_FLOAT];
            assign ch_if.rx_slot_float_enable = ctrl_r[g][CTRL_SLOT_FLOAT];
            assign ch_if.rx_port_a_function = pcfg_r[g][PCFG_RX_LSB +: FN_W];
            assign ch_if.rx_multi_port_a = rx_multi_port_a_i[g];
            assign ch_if.rx_slot_active = rx_slot_active_i[g];

            psw_tx_float u_tx (
                .ch (ch_if)
            );

            psw_rx_float u_rx (
                .ch (ch_if)
            );

            // Shared board signal with opposite port polarities swaps roles
            assign tx_float[g] = ch_if.tx_float;
            assign rx_float[g] = ch_if.rx_float;
            assign tx_fn_on[g] = ch_if.tx_fn_on;
            assign rx_fn_on[g] = ch_if.rx_fn_on;
            assign rx_data_oe[g] = ch_if.rx_data_oe;
            assign rx_clk_oe[g] = ch_if.rx_clk_oe;
            assign rx_pullup[g] = ch_if.rx_pullup_en;

            always_comb begin
                stat[g] = '0;
                stat[g][STAT_TX_FLOAT] = tx_float[g];
                stat[g][STAT_RX_FLOAT] = rx_float[g];
                stat[g][STAT_TX_PIN] = tx_multi_port_a_i[g];
                stat[g][STAT_RX_PIN] = rx_multi_port_a_i[g];
                stat[g][STAT_TX_FN_ON] = tx_fn_on[g];
                stat[g][STAT_RX_FN_ON] = rx_fn_on[g];
            end

            // Role swap flags let software see a board-driven switchover
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    tx_float_prev_r[g] <= 1'b0;
                    rx_float_prev_r[g] <= 1'b0;
                end else begin
                    tx_float_prev_r[g] <= tx_float[g];
                    rx_float_prev_r[g] <= rx_float[g];
                end
            end

            always_comb begin
                evt_set = '0;
                evt_set[EVT_TX_SWAP] = tx_float[g] ^ tx_float_prev_r[g];
                evt_set[EVT_RX_SWAP] = rx_float[g] ^ rx_float_prev_r[g];
                evt_clr = wr_evt ? wb_dat_i[EVT_W-1:0] : '0;
            end

            // A new swap in the clear cycle survives the clear
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    evt_r[g] <= EVT_RST;
                end else begin
                    evt_r[g] <= (evt_r[g] & ~evt_clr) | evt_set;
                end
            end

            // Analog front-end settings are held in flops
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    line_mon_r[g] <= 1'b0;
                    term_sw_r[g] <= 1'b0;
                    analog_sw_r[g] <= 1'b0;
                end else begin
                    line_mon_r[g] <= ctrl_r[g][CTRL_LINE_MON];
                    term_sw_r[g] <= ctrl_r[g][CTRL_TERM_SW];
                    analog_sw_r[g] <= ctrl_r[g][CTRL_ANALOG_SW];
                end
            end
        end
    endgenerate

    // Enables stay combinational so a board swap needs no bus traffic
    assign tx_line_oe_o = ~tx_float;
    assign rx_data_oe_o = rx_data_oe;
    assign rx_signaling_oe_o = rx_data_oe;
    assign rx_sys_clock_oe_o = rx_clk_oe;
    assign rx_frame_marker_oe_o = rx_clk_oe;
    assign rx_pullup_en_o = rx_pullup;
    // Equalizer raises sensitivity by LINE_MON_ATTEN_DB in this mode
    assign line_monitor_mode_o = line_mon_r;
    assign term_resistor_switch_o = term_sw_r;
    assign analog_switch_o = analog_sw_r;

endmodule

// ==== core/psw_pkg.sv ====
package psw_pkg;

    localparam int NUM_CH = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FN_W = 4;

    // Per-channel register window: channel index in the upper nibble
    localparam int CH_SEL_LSB = 4;
    localparam int CH_SEL_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_PORTCFG = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_EVENT = 4'hC;

    // Control register fields
    localparam int CTRL_W = 6;
    localparam int CTRL_TX_FLOAT = 0;
    localparam int CTRL_RX_FLOAT = 1;
    localparam int CTRL_SLOT_FLOAT = 2;
    localparam int CTRL_LINE_MON = 3;
    localparam int CTRL_TERM_SW = 4;
    localparam int CTRL_ANALOG_SW = 5;
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

    // Port function register fields
    localparam int PCFG_W = 8;
    localparam int PCFG_TX_LSB = 0;
    localparam int PCFG_RX_LSB = 4;
    localparam logic [PCFG_W-1:0] PCFG_RST = 8'h00;

    // Multi-function port codes
    localparam logic [FN_W-1:0] FN_TX_FLOAT_HI = 4'h8;
    localparam logic [FN_W-1:0] FN_TX_FLOAT_LO = 4'hE;
    localparam logic [FN_W-1:0] FN_RX_SYS_FLOAT = 4'hD;

    // Status register fields
    localparam int STAT_W = 6;
    localparam int STAT_TX_FLOAT = 0;
    localparam int STAT_RX_FLOAT = 1;
    localparam int STAT_TX_PIN = 2;
    localparam int STAT_RX_PIN = 3;
    localparam int STAT_TX_FN_ON = 4;
    localparam int STAT_RX_FN_ON = 5;

    // Event register fields, write one to clear
    localparam int EVT_W = 2;
    localparam int EVT_TX_SWAP = 0;
    localparam int EVT_RX_SWAP = 1;
    localparam logic [EVT_W-1:0] EVT_RST = 2'h0;

    // Monitor-mode sensitivity, resistive attenuation in dB
    localparam int LINE_MON_ATTEN_DB = 20;

    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

endpackage

// ==== core/psw_chan_if.sv ====
`timescale 1ns/1ps
interface psw_chan_if;
    import psw_pkg::*;

    logic tx_line_float_bit;
    logic [FN_W-1:0] tx_port_a_function;
    logic tx_multi_port_a;
    logic tx_float;
    logic tx_fn_on;

    logic rx_sys_float_bit;
    logic rx_slot_float_enable;
    logic [FN_W-1:0] rx_port_a_function;
    logic rx_multi_port_a;
    logic rx_slot_active;
    logic rx_float;
    logic rx_fn_on;
    logic rx_data_oe;
    logic rx_clk_oe;
    logic rx_pullup_en;

    modport tx (
        input tx_line_float_bit,
        input tx_port_a_function,
        input tx_multi_port_a,
        output tx_float,
        output tx_fn_on
    );

    modport rx (
        input rx_sys_float_bit,
        input rx_slot_float_enable,
        input rx_port_a_function,
        input rx_multi_port_a,
        input rx_slot_active,
        output rx_float,
        output rx_fn_on,
        output rx_data_oe,
        output rx_clk_oe,
        output rx_pullup_en
    );

endinterface

// ==== core/psw_tx_float.sv ====
`timescale 1ns/1ps
module psw_tx_float
    import psw_pkg::*;
(
    psw_chan_if.tx ch
);

    logic fn_hi;
    logic fn_lo;
    logic pin_asserted;

    always_comb begin
        fn_hi = (ch.tx_port_a_function == FN_TX_FLOAT_HI);
        fn_lo = (ch.tx_port_a_function == FN_TX_FLOAT_LO);
        pin_asserted = 1'b0;
        if (fn_hi) begin
            pin_asserted = ch.tx_multi_port_a;
        end else if (fn_lo) begin
            pin_asserted = ~ch.tx_multi_port_a;
        end
    end

    // No clocking here so the board signal reaches the driver at once
    assign ch.tx_fn_on = fn_hi | fn_lo;
    assign ch.tx_float = ch.tx_line_float_bit | pin_asserted;

endmodule

// ==== core/psw_rx_float.sv ====
`timescale 1ns/1ps
module psw_rx_float
    import psw_pkg::*;
(
    psw_chan_if.rx ch
);

    logic fn_on;
    logic eff_float;
    logic slot_idle;

    always_comb begin
        fn_on = (ch.rx_port_a_function == FN_RX_SYS_FLOAT);
        eff_float = ch.rx_sys_float_bit;
        if (fn_on) begin
            eff_float = ch.rx_sys_float_bit ^ ch.rx_multi_port_a;
        end
        slot_idle = ch.rx_slot_float_enable & ~ch.rx_slot_active;
    end

    assign ch.rx_fn_on = fn_on;
    assign ch.rx_float = eff_float;
    // Constant float overrides the slot enable and carries no pull
    assign ch.rx_clk_oe = ~eff_float;
    assign ch.rx_data_oe = ~eff_float & ~slot_idle;
    assign ch.rx_pullup_en = ~eff_float & slot_idle;

endmodule

// ==== tb/psw_board_model.sv ====
`timescale 1ns/1ps
module psw_board_model (
    input wire logic board_sel_i,
    input wire logic [1:0] tx_aux_i,
    input wire logic [1:0] rx_aux_i,
    output logic [3:0] tx_port_o,
    output logic [3:0] rx_port_o
);
    // One shared board line feeds both ports of the redundancy pair
    assign tx_port_o = {tx_aux_i, {2{board_sel_i}}};
    assign rx_port_o = {rx_aux_i, {2{board_sel_i}}};
endmodule

// ==== tb/psw_top_asserts.sv ====
`timescale 1ns/1ps
module psw_top_asserts
    import psw_pkg::*;
#(
    parameter int N_CH = NUM_CH
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [N_CH-1:0] tx_multi_port_a_i,
    input wire logic [N_CH-1:0] rx_multi_port_a_i,
    input wire logic [N_CH-1:0] rx_slot_active_i,
    input wire logic [N_CH-1:0] tx_line_oe_o,
    input wire logic [N_CH-1:0] rx_data_oe_o,
    input wire logic [N_CH-1:0] rx_signaling_oe_o,
    input wire logic [N_CH-1:0] rx_sys_clock_oe_o,
    input wire logic [N_CH-1:0] rx_frame_marker_oe_o,
    input wire logic [N_CH-1:0] rx_pullup_en_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_rx_float_all: assert property (
        (~rx_sys_clock_oe_o & (rx_data_oe_o | rx_signaling_oe_o | rx_frame_marker_oe_o | rx_pullup_en_o)) == '0)
        else $error("receive outputs not floated together");
    a_marker_clock: assert property (
        rx_frame_marker_oe_o == rx_sys_clock_oe_o)
        else $error("frame marker enable differs from clock enable");
    a_data_sig: assert property (
        rx_signaling_oe_o == rx_data_oe_o)
        else $error("signaling enable differs from data enable");
    a_pullup_cause: assert property (
        (rx_pullup_en_o & (rx_slot_active_i | ~rx_sys_clock_oe_o | rx_data_oe_o)) == '0)
        else $error("pull-up outside an idle slot float");
    a_slot_drive: assert property (
        (rx_slot_active_i & rx_sys_clock_oe_o & ~rx_data_oe_o) == '0)
        else $error("data floated during active slot");
    a_tx_follows: assert property (
        !wb_ack_o && !$past(wb_ack_o) && !$past(rst_i) && $stable(tx_multi_port_a_i) |-> $stable(tx_line_oe_o))
        else $error("transmit enable moved without cause");
    a_rx_follows: assert property (
        !wb_ack_o && !$past(wb_ack_o) && !$past(rst_i) && $stable(rx_multi_port_a_i) |-> $stable(rx_sys_clock_oe_o))
        else $error("receive enable moved without cause");
endmodule

bind psw_top psw_top_asserts #(.N_CH(N_CH)) u_psw_top_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .tx_multi_port_a_i(tx_multi_port_a_i), .rx_multi_port_a_i(rx_multi_port_a_i),
    .rx_slot_active_i(rx_slot_active_i), .tx_line_oe_o(tx_line_oe_o), .rx_data_oe_o(rx_data_oe_o),
    .rx_signaling_oe_o(rx_signaling_oe_o), .rx_sys_clock_oe_o(rx_sys_clock_oe_o),
    .rx_frame_marker_oe_o(rx_frame_marker_oe_o), .rx_pullup_en_o(rx_pullup_en_o)
);

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import psw_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, ack, board;
    logic [7:0] adr;
    logic [31:0] wdat, rdat;
    logic [3:0] sel, slot, txp, rxp, tx_oe, d_oe, s_oe, c_oe, f_oe, pu, lm, ts, as;
    logic [1:0] tx_aux, rx_aux;
    logic [3:0] code;
    logic b, p, se, sa, fl;
    int errors, cmp_count, cycles;

    psw_board_model u_psw_board_model (.board_sel_i(board), .tx_aux_i(tx_aux), .rx_aux_i(rx_aux),
        .tx_port_o(txp), .rx_port_o(rxp));
    psw_top u_psw_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tx_multi_port_a_i(txp), .rx_multi_port_a_i(rxp), .rx_slot_active_i(slot),
        .tx_line_oe_o(tx_oe), .rx_data_oe_o(d_oe), .rx_signaling_oe_o(s_oe), .rx_sys_clock_oe_o(c_oe),
        .rx_frame_marker_oe_o(f_oe), .rx_pullup_en_o(pu), .line_monitor_mode_o(lm),
        .term_resistor_switch_o(ts), .analog_switch_o(as));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Bounded so a missing ack ends the run instead of hanging it
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            errors++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h00_0000, d};
        sel <= s;
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            @(posedge clk_i);
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 4'h1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 8'h00, 4'h1);
        chk("read data", exp, rdat);
    endtask

    initial begin
        {rst_i, cyc, stb, we, adr, wdat, sel, board, tx_aux, rx_aux} = '0;
        rst_i = 1'b1;
        slot = 4'hF;
        {errors, cmp_count, cycles} = '0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk("tx enable", 4'hF, tx_oe);
        chk("clock enable", 4'hF, c_oe);
        chk("monitor", 4'h0, lm);
        rd(8'h00, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        wr(8'h20, 8'h01);
        #1 chk("tx enable", 4'hB, tx_oe);
        wb(1'b1, 8'h20, 8'h00, 4'h0);
        #1 chk("tx enable", 4'hB, tx_oe);
        for (int k = 0; k < 8; k++) begin
            code = k[2] ? FN_TX_FLOAT_LO : FN_TX_FLOAT_HI;
            wr(8'h24, {4'h0, code});
            wr(8'h20, {7'h00, k[0]});
            tx_aux <= {1'b0, k[1]};
            @(posedge clk_i);
            fl = k[0] | (k[2] ? !k[1] : k[1]);
            #1 chk("tx enable 2", {31'h0, !fl}, {31'h0, tx_oe[2]});
        end
        wr(8'h24, 8'h00);
        wr(8'h20, 8'h00);
        for (int k = 0; k < 32; k++) begin
            {code[0], b, p, se, sa} = k[4:0];
            wr(8'h34, code[0] ? {FN_RX_SYS_FLOAT, 4'h0} : 8'h00);
            wr(8'h30, {5'h00, se, b, 1'b0});
            rx_aux <= {p, 1'b0};
            slot <= {sa, 3'h7};
            @(posedge clk_i);
            fl = b ^ (code[0] & p);
            #1;
            chk("clock enable 3", {31'h0, !fl}, {31'h0, c_oe[3]});
            chk("marker enable 3", {31'h0, !fl}, {31'h0, f_oe[3]});
            chk("data enable 3", {31'h0, !fl && !(se && !sa)}, {31'h0, d_oe[3]});
            chk("signaling enable 3", {31'h0, !fl && !(se && !sa)}, {31'h0, s_oe[3]});
            chk("pullup 3", {31'h0, !fl && se && !sa}, {31'h0, pu[3]});
        end
        wr(8'h34, 8'h00);
        wr(8'h30, 8'h00);
        wr(8'h04, 8'hD8);
        wr(8'h14, 8'hDE);
        wr(8'h10, 8'h0A);
        slot <= 4'hF;
        for (int s = 0; s < 2; s++) begin
            @(posedge clk_i);
            board <= s[0];
            #1;
            chk("tx pair", s ? 32'h2 : 32'h1, {30'h0, tx_oe[1:0]});
            chk("rx pair", s ? 32'h2 : 32'h1, {30'h0, c_oe[1:0]});
        end
        chk("monitor", 4'h2, lm);
        chk("switches", 8'h00, {ts, as});
        rd(8'h18, 32'h0000_003C);
        rd(8'h1C, 32'h0000_0003);
        wr(8'h1C, 8'h03);
        rd(8'h1C, 32'h0000_0000);
        wr(8'h30, 8'h30);
        @(posedge clk_i);
        #1 chk("switches 3", 8'h88, {ts, as});
        wr(8'h30, 8'h00);
        results();
    end
endmodule
